/* File: shared/usm_pkg.sv */
// Purpose: constants and types for the synchronous master serial port
// Assumes: 20 MHz clock_i; plain register port with 4-bit address
// Notes: register offsets are word indices on the plain register port
//
// Operation
// RULE1: Software may slow the baud rate to 9/13 to catch a 13-bit break.
// RULE2: Wake-on-edge watches two line transitions, flags receive, then receives the next byte.
// RULE3: After a break software may arm autobaud once transmit-empty has been seen.
// RULE4: Clock-source-select, transmit status bit 7, makes the port the clock master.
// RULE5: Transfers are half-duplex; transmit and receive never overlap.
// RULE6: Clocked-mode bit selects synchronous mode; port enable turns pins into clock and data.
// RULE7: As master the port drives the shift clock for every bit.
// RULE8: Clock idle polarity bit sets the resting level of the shift clock.
// RULE9: Shift register reloads from the holding buffer right after the last bit.
// RULE10: The reload takes one cycle, then the transmit-buffer-empty flag is set.
// RULE11: Transmit-buffer-empty sets regardless of enable, clears only on a buffer write; here it sets only at reset and when the buffer loads into the shifter.
// RULE12: Shift-register-empty is read-only status with no interrupt.
// RULE13: The transmit shift register has no software address.
// RULE14: Software configures divisor, mode, enables, ninth bit, then writes the buffer.
// RULE15: Software programs the 16-bit divisor and the wide-divisor select first.
// RULE16: Reception starts when single or continuous receive enable is set.
// RULE17: Received data is sampled on the falling shift clock edge; here it is sampled as the clock returns to idle, rising when pol is 1.
// RULE18: Single receive takes one word; continuous runs until cleared and wins.
// RULE19: Software clears both receive enables before setting up reception.
// RULE20: A finished word sets receive-ready and requests an interrupt if enabled.
// RULE21: Software reads status for ninth bit and errors before the data buffer.
// RULE22: Clearing continuous receive clears the receive error indication.
// RULE23: Wake-on-edge clears itself on the rising line edge after the wake event.
// RULE24: Shift clock period comes from the baud counter, idling between words.

package usm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_RX_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RX_DATA_BUFFER = 4'h1;
  localparam logic [3:0] OFS_TX_HOLDING_BUFFER = 4'h2;
  localparam logic [3:0] OFS_TX_STATUS_CONTROL = 4'h3;
  localparam logic [3:0] OFS_BAUD_CONTROL = 4'h4;
  localparam logic [3:0] OFS_BAUD_DIVISOR_HIGH = 4'h5;
  localparam logic [3:0] OFS_BAUD_DIVISOR_LOW = 4'h6;
  localparam logic [3:0] OFS_PERIPHERAL_FLAGS_ONE = 4'h7;
  localparam logic [3:0] OFS_PERIPHERAL_ENABLES_ONE = 4'h8;

  // rx_status_control fields
  localparam int RCS_PORT_ENABLE = 7;
  localparam int RCS_RX_NINTH_ENABLE = 6;
  localparam int RCS_SINGLE_RECEIVE = 5;
  localparam int RCS_CONT_RECEIVE = 4;
  localparam int RCS_OVERRUN = 1;
  localparam int RCS_RX_NINTH_VALUE = 0;

  // tx_status_control fields
  localparam int TXS_CLOCK_SOURCE = 7;
  localparam int TXS_TX_NINTH_ENABLE = 6;
  localparam int TXS_TRANSMIT_ENABLE = 5;
  localparam int TXS_SYNC_MODE = 4;
  localparam int TXS_SEND_BREAK = 3;
  localparam int TXS_HIGH_SPEED = 2;
  localparam int TXS_SHIFT_REG_EMPTY = 1;
  localparam int TXS_TX_NINTH_VALUE = 0;

  // baud_control fields
  localparam int BDC_RX_IDLE = 6;
  localparam int BDC_CLOCK_IDLE_POL = 4;
  localparam int BDC_WIDE_DIVISOR = 3;
  localparam int BDC_WAKE_ON_EDGE = 1;
  localparam int BDC_AUTOBAUD_ARM = 0;

  // Flag and enable fields
  localparam int PF_RX_READY = 5;
  localparam int PF_TX_EMPTY = 4;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic RST_TX_EMPTY_FLAG = 1'b1;

  // Last bit index of an 8-bit and a 9-bit word
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef enum logic [1:0] {S_IDLE, S_TX, S_RX} usm_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } usm_bus_req_t;

  typedef struct packed {
    logic ck;
    logic ck_oe;
    logic dt;
    logic dt_oe;
  } usm_pins_t;

endpackage : usm_pkg

/* File: hw/usm_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clock_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps

module usm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import usm_pkg::*;

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  genvar gi;
  for (gi = 0; gi < WIDTH; gi++) begin : g_bit
    always_ff @(posedge clock_i) begin
      if (srst_i) begin
        meta_ff[gi] <= 1'b1;
        sync_ff[gi] <= 1'b1;
      end else begin
        meta_ff[gi] <= async_i[gi];
        sync_ff[gi] <= meta_ff[gi];
      end
    end
  end

  assign sync_o = sync_ff;

endmodule : usm_sync

/* File: hw/usm_top.sv */
// Purpose: synchronous master serial port with wake-on-edge break detection
// Assumes: registers on a plain port, read data one cycle after the strobe
// Notes: clock line is driven by this block; only the data line is sampled
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module usm_top (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire usm_pkg::usm_bus_req_t bus_i,
  output logic [usm_pkg::DATA_W-1:0] rdata_o,
  input wire logic dt_i,
  output usm_pkg::usm_pins_t pins_o,
  output logic rx_irq_o,
  output logic tx_irq_o
);
  import usm_pkg::*;

  typedef struct packed {
    usm_phase_t phase;
    logic port_en;
    logic rx9en;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic oerr;
    logic rx9d;
    logic clock_source_select;
    logic tx9en;
    logic transmit_enable;
    logic syncm;
    logic sendb;
    logic brgh;
    logic tx_ninth_value;
    logic pol;
    logic wide;
    logic wake_on_edge_enable;
    logic abd;
    logic pie_rx;
    logic pie_tx;
    logic [7:0] brg_hi;
    logic [7:0] brg_lo;
    logic [7:0] hold;
    logic hold_full;
    logic tx_buffer_empty_flag;
    logic [8:0] shreg;
    logic [3:0] bitcnt;
    logic half;
    logic [15:0] brg_cnt;
    logic [7:0] rxbuf;
    logic rx_ready;
    logic woke;
    logic rx_prev;
    logic [7:0] rdata;
    usm_pins_t pins;
    logic rx_irq;
    logic tx_irq;
  } usm_state_t;

  usm_state_t st_ff;
  usm_state_t nxt_st;
  logic rx_s;

  usm_sync #(
    .WIDTH(1)
  ) u_dt_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .async_i(dt_i),
    .sync_o(rx_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic [15:0] divisor;
    logic tick;
    logic master;
    logic rx_on;
    logic [3:0] last_bit;
    divisor = 16'h0000;
    tick = 1'b0;
    master = 1'b0;
    rx_on = 1'b0;
    last_bit = LAST_BIT_8;
    nxt_st = st_ff;
    nxt_st.rdata = RST_REG;
    // RULE15 divisor width select
    divisor = st_ff.wide ? {st_ff.brg_hi, st_ff.brg_lo} : {8'h00, st_ff.brg_lo};
    tick = (st_ff.brg_cnt == 16'h0000);
    // RULE4 RULE6 master mode enable
    master = st_ff.syncm & st_ff.clock_source_select & st_ff.port_en;
    // RULE16 receive enable
    rx_on = (st_ff.single_receive_enable | st_ff.continuous_receive_enable) & ~st_ff.wake_on_edge_enable;

    // RULE24 baud counter paces half bits
    if (st_ff.phase == S_IDLE || tick) begin
      nxt_st.brg_cnt = divisor;
    end else begin
      nxt_st.brg_cnt = st_ff.brg_cnt - 16'h0001;
    end

    unique case (st_ff.phase)
      S_IDLE: begin
        nxt_st.half = 1'b0;
        nxt_st.bitcnt = 4'h0;
        // RULE5 receive blocks transmit
        if (master && rx_on) begin
          nxt_st.phase = S_RX;
        end else if (master && st_ff.transmit_enable && st_ff.hold_full) begin
          // RULE10 one-cycle reload sets empty flag
          nxt_st.shreg = {st_ff.tx_ninth_value, st_ff.hold};
          nxt_st.hold_full = 1'b0;
          nxt_st.tx_buffer_empty_flag = 1'b1;
          nxt_st.phase = S_TX;
        end
      end
      S_TX: begin
        last_bit = st_ff.tx9en ? LAST_BIT_9 : LAST_BIT_8;
        if (!master) begin
          nxt_st.phase = S_IDLE;
        end else if (tick) begin
          nxt_st.half = ~st_ff.half;
          if (st_ff.half) begin
            nxt_st.shreg = {1'b0, st_ff.shreg[8:1]};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == last_bit) begin
              nxt_st.bitcnt = 4'h0;
              // RULE9 reload right after last bit
              if (st_ff.transmit_enable && st_ff.hold_full && !rx_on) begin
                nxt_st.shreg = {st_ff.tx_ninth_value, st_ff.hold};
                nxt_st.hold_full = 1'b0;
                nxt_st.tx_buffer_empty_flag = 1'b1;
              end else begin
                nxt_st.phase = S_IDLE;
              end
            end
          end
        end
      end
      S_RX: begin
        last_bit = st_ff.rx9en ? LAST_BIT_9 : LAST_BIT_8;
        if (!master || !rx_on) begin
          nxt_st.phase = S_IDLE;
        end else if (tick) begin
          nxt_st.half = ~st_ff.half;
          if (!st_ff.half) begin
            // RULE17 sample as the clock returns to idle level, a falling edge only when pol is 0
            nxt_st.shreg = {rx_s, st_ff.shreg[8:1]};
          end else begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == last_bit) begin
              nxt_st.bitcnt = 4'h0;
              // RULE18 single word unless continuous
              if (!st_ff.continuous_receive_enable) begin
                nxt_st.single_receive_enable = 1'b0;
                nxt_st.phase = S_IDLE;
              end
            end
          end
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Register port; data reads and buffer writes act after the shifter

    if (bus_i.wr) begin
      unique case (bus_i.addr)
        OFS_RX_STATUS_CONTROL: begin
          nxt_st.port_en = bus_i.wdata[RCS_PORT_ENABLE];
          nxt_st.rx9en = bus_i.wdata[RCS_RX_NINTH_ENABLE];
          nxt_st.single_receive_enable = bus_i.wdata[RCS_SINGLE_RECEIVE];
          nxt_st.continuous_receive_enable = bus_i.wdata[RCS_CONT_RECEIVE];
          // RULE22 clearing continuous receive clears error
          if (!bus_i.wdata[RCS_CONT_RECEIVE]) begin
            nxt_st.oerr = 1'b0;
          end
        end
        OFS_TX_HOLDING_BUFFER: begin
          // RULE11 only a buffer write clears the flag
          nxt_st.hold = bus_i.wdata;
          nxt_st.hold_full = 1'b1;
          nxt_st.tx_buffer_empty_flag = 1'b0;
        end
        OFS_TX_STATUS_CONTROL: begin
          nxt_st.clock_source_select = bus_i.wdata[TXS_CLOCK_SOURCE];
          nxt_st.tx9en = bus_i.wdata[TXS_TX_NINTH_ENABLE];
          nxt_st.transmit_enable = bus_i.wdata[TXS_TRANSMIT_ENABLE];
          nxt_st.syncm = bus_i.wdata[TXS_SYNC_MODE];
          nxt_st.sendb = bus_i.wdata[TXS_SEND_BREAK];
          nxt_st.brgh = bus_i.wdata[TXS_HIGH_SPEED];
          nxt_st.tx_ninth_value = bus_i.wdata[TXS_TX_NINTH_VALUE];
        end
        OFS_BAUD_CONTROL: begin
          nxt_st.pol = bus_i.wdata[BDC_CLOCK_IDLE_POL];
          nxt_st.wide = bus_i.wdata[BDC_WIDE_DIVISOR];
          nxt_st.wake_on_edge_enable = bus_i.wdata[BDC_WAKE_ON_EDGE];
          nxt_st.abd = bus_i.wdata[BDC_AUTOBAUD_ARM];
          nxt_st.woke = 1'b0;
        end
        OFS_BAUD_DIVISOR_HIGH: nxt_st.brg_hi = bus_i.wdata;
        OFS_BAUD_DIVISOR_LOW: nxt_st.brg_lo = bus_i.wdata;
        OFS_PERIPHERAL_ENABLES_ONE: begin
          nxt_st.pie_rx = bus_i.wdata[PF_RX_READY];
          nxt_st.pie_tx = bus_i.wdata[PF_TX_EMPTY];
        end
        default: ;
      endcase
    end

    if (bus_i.rd) begin
      unique case (bus_i.addr)
        OFS_RX_STATUS_CONTROL: begin
          nxt_st.rdata[RCS_PORT_ENABLE] = st_ff.port_en;
          nxt_st.rdata[RCS_RX_NINTH_ENABLE] = st_ff.rx9en;
          nxt_st.rdata[RCS_SINGLE_RECEIVE] = st_ff.single_receive_enable;
          nxt_st.rdata[RCS_CONT_RECEIVE] = st_ff.continuous_receive_enable;
          nxt_st.rdata[RCS_OVERRUN] = st_ff.oerr;
          nxt_st.rdata[RCS_RX_NINTH_VALUE] = st_ff.rx9d;
        end
        OFS_RX_DATA_BUFFER: begin
          nxt_st.rdata = st_ff.rxbuf;
          nxt_st.rx_ready = 1'b0;
        end
        OFS_TX_HOLDING_BUFFER: nxt_st.rdata = st_ff.hold;
        OFS_TX_STATUS_CONTROL: begin
          nxt_st.rdata[TXS_CLOCK_SOURCE] = st_ff.clock_source_select;
          nxt_st.rdata[TXS_TX_NINTH_ENABLE] = st_ff.tx9en;
          nxt_st.rdata[TXS_TRANSMIT_ENABLE] = st_ff.transmit_enable;
          nxt_st.rdata[TXS_SYNC_MODE] = st_ff.syncm;
          nxt_st.rdata[TXS_SEND_BREAK] = st_ff.sendb;
          nxt_st.rdata[TXS_HIGH_SPEED] = st_ff.brgh;
          // RULE12 RULE13 shifter visible only as empty status
          nxt_st.rdata[TXS_SHIFT_REG_EMPTY] = (st_ff.phase != S_TX);
          nxt_st.rdata[TXS_TX_NINTH_VALUE] = st_ff.tx_ninth_value;
        end
        OFS_BAUD_CONTROL: begin
          nxt_st.rdata[BDC_RX_IDLE] = (st_ff.phase != S_RX);
          nxt_st.rdata[BDC_CLOCK_IDLE_POL] = st_ff.pol;
          nxt_st.rdata[BDC_WIDE_DIVISOR] = st_ff.wide;
          nxt_st.rdata[BDC_WAKE_ON_EDGE] = st_ff.wake_on_edge_enable;
          nxt_st.rdata[BDC_AUTOBAUD_ARM] = st_ff.abd;
        end
        OFS_BAUD_DIVISOR_HIGH: nxt_st.rdata = st_ff.brg_hi;
        OFS_BAUD_DIVISOR_LOW: nxt_st.rdata = st_ff.brg_lo;
        OFS_PERIPHERAL_FLAGS_ONE: begin
          nxt_st.rdata[PF_RX_READY] = st_ff.rx_ready;
          nxt_st.rdata[PF_TX_EMPTY] = st_ff.tx_buffer_empty_flag;
        end
        OFS_PERIPHERAL_ENABLES_ONE: begin
          nxt_st.rdata[PF_RX_READY] = st_ff.pie_rx;
          nxt_st.rdata[PF_TX_EMPTY] = st_ff.pie_tx;
        end
        default: nxt_st.rdata = RST_REG;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Word completion and wake events; hardware sets win over clears

    if (st_ff.phase == S_RX && master && rx_on && tick && st_ff.half && st_ff.bitcnt == last_bit) begin
      // RULE20 word done sets receive-ready
      if (st_ff.rx_ready) begin
        nxt_st.oerr = 1'b1;
      end else begin
        nxt_st.rx_ready = 1'b1;
        nxt_st.rxbuf = st_ff.rx9en ? st_ff.shreg[7:0] : st_ff.shreg[8:1];
        nxt_st.rx9d = st_ff.rx9en ? st_ff.shreg[8] : 1'b0;
      end
    end

    nxt_st.rx_prev = rx_s;
    if (st_ff.wake_on_edge_enable && st_ff.port_en) begin
      // RULE2 falling line edge is the wake event
      if (!st_ff.woke && st_ff.rx_prev && !rx_s) begin
        nxt_st.woke = 1'b1;
        nxt_st.rx_ready = 1'b1;
      end
      // RULE23 rising edge after wake clears enable
      if (st_ff.woke && !st_ff.rx_prev && rx_s) begin
        nxt_st.woke = 1'b0;
        nxt_st.wake_on_edge_enable = 1'b0;
      end
    end

    // RULE7 RULE8 master drives clock, idle level from polarity
    nxt_st.pins.ck_oe = nxt_st.port_en & nxt_st.syncm & nxt_st.clock_source_select;
    nxt_st.pins.ck = (nxt_st.phase != S_IDLE && !nxt_st.half) ? ~nxt_st.pol : nxt_st.pol;
    nxt_st.pins.dt_oe = (nxt_st.phase == S_TX);
    nxt_st.pins.dt = nxt_st.shreg[0];
    nxt_st.rx_irq = nxt_st.rx_ready & nxt_st.pie_rx;
    nxt_st.tx_irq = nxt_st.tx_buffer_empty_flag & nxt_st.pie_tx;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_ff <= '0;
      st_ff.tx_buffer_empty_flag <= RST_TX_EMPTY_FLAG;
      st_ff.rx_prev <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign pins_o = st_ff.pins;
  assign rx_irq_o = st_ff.rx_irq;
  assign tx_irq_o = st_ff.tx_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence s_tx_load;
    st_ff.phase == S_IDLE && st_ff.hold_full ##1 st_ff.phase == S_TX;
  endsequence

  sequence s_hold_write;
    bus_i.wr && bus_i.addr == OFS_TX_HOLDING_BUFFER;
  endsequence

  // RULE10 flag set with load
  a_load_sets_empty: assert property (s_tx_load |-> st_ff.tx_buffer_empty_flag && !st_ff.hold_full) // RULE10
    else $error("transmit empty flag not set on load");

  // RULE11 flag cleared only by buffer write
  a_empty_flag_sticky: assert property ($fell(st_ff.tx_buffer_empty_flag) |-> $past(bus_i.wr) && $past(bus_i.addr) == OFS_TX_HOLDING_BUFFER) // RULE11
    else $error("transmit empty flag cleared without buffer write");

  // RULE5 no drive during reception
  a_half_duplex: assert property (st_ff.phase == S_RX |-> !st_ff.pins.dt_oe) // RULE5
    else $error("data line driven while receiving");

  // RULE8 clock rests at polarity between words
  a_clock_idle: assert property (st_ff.phase == S_IDLE |-> st_ff.pins.ck == st_ff.pol) // RULE8
    else $error("shift clock not at idle level");

  // RULE4 clock driven only as master
  a_master_drive: assert property (st_ff.pins.ck_oe |-> st_ff.clock_source_select && st_ff.port_en && st_ff.syncm) // RULE4
    else $error("clock driven outside master mode");

  // RULE18 single receive ends after one word
  a_single_word: assert property ( // RULE18
    st_ff.phase == S_RX && !st_ff.continuous_receive_enable ##1 st_ff.phase == S_IDLE && !st_ff.continuous_receive_enable
    |-> !st_ff.single_receive_enable || !$past(st_ff.single_receive_enable) || $past(st_ff.bitcnt) == 4'h0)
    else $error("single receive did not clear after word");

  // RULE20 irq follows flag and enable
  a_rx_irq: assert property (st_ff.rx_ready && st_ff.pie_rx && !bus_i.rd ##1 !bus_i.rd |-> rx_irq_o) // RULE20
    else $error("receive interrupt missing");

  // RULE22 error clear with continuous receive
  a_err_clear: assert property ( // RULE22
    bus_i.wr && bus_i.addr == OFS_RX_STATUS_CONTROL && !bus_i.wdata[RCS_CONT_RECEIVE]
    && st_ff.phase != S_RX |=> !st_ff.oerr)
    else $error("error survived clearing continuous receive");

  // RULE23 enable drops on rising edge after wake
  a_wake_clear: assert property ( // RULE23
    st_ff.wake_on_edge_enable && st_ff.woke && st_ff.port_en && !st_ff.rx_prev && rx_s
    && !(bus_i.wr && bus_i.addr == OFS_BAUD_CONTROL) |=> !st_ff.wake_on_edge_enable)
    else $error("wake enable not cleared");

  // RULE12 shift register reads busy while shifting
  a_shift_empty: assert property ( // RULE12
    bus_i.rd && bus_i.addr == OFS_TX_STATUS_CONTROL && st_ff.phase == S_TX |=> !rdata_o[TXS_SHIFT_REG_EMPTY])
    else $error("shift register empty during transmit");

  // RULE11 buffer write clears the empty flag
  a_write_clears: assert property (s_hold_write |=> !st_ff.tx_buffer_empty_flag) // RULE11
    else $error("transmit empty flag not cleared by buffer write");

endmodule : usm_top

/* File: tb/usm_slave_model.sv */
// Purpose: serial slave on the shift clock and data lines
// Assumes: clock line moves only just after clock_i edges
// Notes: outside receive frames the line toggles every cycle
`timescale 1ns/1ps

module usm_slave_model (
  input wire logic clock_i,
  input wire logic ck_i,
  input wire logic ck_oe_i,
  input wire logic dt_i,
  input wire logic dt_oe_i,
  input wire logic pol_i,
  input wire logic [3:0] nbits_i,
  input wire logic [8:0] rx_word_i,
  input wire logic hold_i,
  input wire logic hold_val_i,
  output logic line_o,
  output int got_o,
  output logic [8:0] word_o
);
  logic line = 1'b0;
  logic idle = 1'b1;
  logic [8:0] cap = '0;
  int tcnt = 0;
  int rcnt = 0;

  initial got_o = 0;
  assign line_o = hold_i ? hold_val_i : line;

  //////////////////////////////
  // Released line never keeps a stale level
  always @(posedge clock_i) begin
    if (idle) begin
      line <= ~line;
    end
  end

  //////////////////////////////
  // Leaving idle level presents a bit, returning captures one
  always @(ck_i or ck_oe_i) begin
    #1;
    if (ck_oe_i !== 1'b1) begin
      tcnt = 0;
      rcnt = 0;
      idle = 1'b1;
    end else if (ck_i != pol_i) begin
      if (!dt_oe_i) begin
        line = rx_word_i[rcnt];
        idle = 1'b0;
        rcnt = (rcnt + 1) % nbits_i;
      end
    end else if (dt_oe_i) begin
      cap[tcnt] = dt_i;
      tcnt++;
      if (tcnt == nbits_i) begin
        word_o = cap & ~(9'h1ff << nbits_i);
        tcnt = 0;
        got_o++;
      end
    end else if (rcnt == 0) begin
      idle = 1'b1;
    end
  end

endmodule : usm_slave_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for the synchronous master port
// Assumes: divisor 3 gives an 8-cycle bit, a 400 ns link clock
// Notes: reads and sent words are checked against queued notes
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; \
  if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end

module tb;
  import usm_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  usm_bus_req_t bus = '0;
  usm_pins_t pins;
  logic [7:0] rdata;
  logic [7:0] d0;
  logic [7:0] d1;
  logic rx_irq;
  logic tx_irq;
  logic line;
  logic dt_w;
  logic hold = 1'b0;
  logic hold_val = 1'b1;
  logic pol = 1'b0;
  logic rd_pend = 1'b0;
  logic rx_on = 1'b0;
  logic [3:0] nbits = 4'h8;
  logic [8:0] rxw = '0;
  logic [8:0] word;
  logic [15:0] rq[$];
  logic [8:0] tq[$];
  int got;
  int seen = 0;
  int fails = 0;
  int compares = 0;
  int seed;

  always #25 clock_i = ~clock_i;
  assign dt_w = pins.dt_oe ? pins.dt : line;

  usm_top u_dut (.clock_i(clock_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
    .dt_i(dt_w), .pins_o(pins), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq));

  usm_slave_model u_slave (.clock_i(clock_i), .ck_i(pins.ck), .ck_oe_i(pins.ck_oe),
    .dt_i(dt_w), .dt_oe_i(pins.dt_oe), .pol_i(pol), .nbits_i(nbits), .rx_word_i(rxw),
    .hold_i(hold), .hold_val_i(hold_val), .line_o(line), .got_o(got), .word_o(word));

  //////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    rq.push_back({m, e});
    @(posedge clock_i);
    bus <= '0;
  endtask : rd

  task automatic wait_rx;
    int n = 0;
    repeat (2) @(posedge clock_i);
    while (rx_irq !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 3000) fails++;
  endtask : wait_rx

  task automatic wait_tx(input int t);
    int n = 0;
    while (got < t && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    if (n >= 3000) fails++;
    repeat (8) @(posedge clock_i);
  endtask : wait_tx

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  //////////////////////////////
  // Takes the oldest note whenever a result shows
  always @(negedge clock_i) begin
    if (rd_pend) begin
      `CHK("read data", rq[0][7:0], rdata & rq[0][15:8])
      void'(rq.pop_front());
    end
    rd_pend = bus.rd;
    if (got != seen) begin
      seen = got;
      `CHK("tx word", tq[0], word)
      void'(tq.pop_front());
    end
    if (rx_on) begin
      `CHK("data drive", 1'b0, pins.dt_oe)
    end
  end

  initial begin : watchdog
    #2000000;
    fails++;
    end_of_test();
  end

  //////////////////////////////
  initial begin : main
    seed = $urandom(28);
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int a = 9; a < 16; a++) begin
      rd(4'(a), 8'h00, 8'hff);
    end
    rd(OFS_TX_STATUS_CONTROL, 8'h02, 8'hff);
    rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h10, 8'hff);
    wr(OFS_BAUD_DIVISOR_HIGH, 8'h00);
    wr(OFS_BAUD_DIVISOR_LOW, 8'h03);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    wr(OFS_PERIPHERAL_ENABLES_ONE, 8'h30);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      nbits <= p[0] ? 4'h9 : 4'h8;
      wr(OFS_BAUD_CONTROL, {3'b000, p[0], 4'h0});
      wr(OFS_TX_STATUS_CONTROL, {1'b1, p[0], 2'b01, 4'h0});
      wr(OFS_TX_STATUS_CONTROL, {1'b1, p[0], 2'b11, 3'b000, p[0]});
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      tq.push_back({p[0], d0});
      tq.push_back({p[0], d1});
      wr(OFS_TX_HOLDING_BUFFER, d0);
      wr(OFS_TX_HOLDING_BUFFER, d1);
      rd(OFS_TX_STATUS_CONTROL, 8'h00, 8'h02);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h00, 8'h10);
      wait_tx(2 * p + 2);
      wr(OFS_PERIPHERAL_FLAGS_ONE, 8'h00);
      rd(OFS_PERIPHERAL_FLAGS_ONE, 8'h10, 8'h10);
      rd(OFS_TX_STATUS_CONTROL, 8'h02, 8'h02);
      `CHK("ck idle", p[0], pins.ck)
      `CHK("tx irq", 1'b1, tx_irq)
    end
    nbits <= 4'h8;
    rxw <= {1'b0, 8'($urandom)};
    wr(OFS_TX_STATUS_CONTROL, 8'hb0);
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rx_on = 1'b1;
    wr(OFS_RX_STATUS_CONTROL, 8'ha0);
    wait_rx();
    rd(OFS_RX_STATUS_CONTROL, 8'h80, 8'hb2);
    rd(OFS_RX_DATA_BUFFER, rxw[7:0], 8'hff);
    d0 = 8'($urandom);
    wr(OFS_RX_STATUS_CONTROL, 8'hb0);
    tq.push_back({1'b0, d0});
    wr(OFS_TX_HOLDING_BUFFER, d0);
    wait_rx();
    rd(OFS_RX_DATA_BUFFER, rxw[7:0], 8'hff);
    wait_rx();
    repeat (160) @(posedge clock_i);
    rd(OFS_RX_STATUS_CONTROL, 8'h92, 8'h92);
    rd(OFS_RX_DATA_BUFFER, rxw[7:0], 8'hff);
    rx_on = 1'b0;
    wr(OFS_RX_STATUS_CONTROL, 8'h80);
    rd(OFS_RX_STATUS_CONTROL, 8'h80, 8'hb2);
    wait_tx(5);
    wr(OFS_TX_STATUS_CONTROL, 8'h30);
    repeat (3) @(posedge clock_i);
    `CHK("ck enable", 1'b0, pins.ck_oe)
    wr(OFS_TX_STATUS_CONTROL, 8'hb0);
    rd(OFS_RX_DATA_BUFFER, 8'h00, 8'h00);
    hold <= 1'b1;
    wr(OFS_BAUD_CONTROL, 8'h12);
    hold_val <= 1'b0;
    wait_rx();
    hold_val <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd(OFS_BAUD_CONTROL, 8'h00, 8'h02);
    rd(OFS_RX_DATA_BUFFER, 8'h00, 8'h00);
    `CHK("tx empty seen", 1'b1, tx_irq)
    wr(OFS_BAUD_CONTROL, 8'h11);
    rd(OFS_BAUD_CONTROL, 8'h11, 8'h13);
    wr(OFS_BAUD_DIVISOR_LOW, 8'h05);
    rd(OFS_BAUD_DIVISOR_LOW, 8'h05, 8'hff);
    hold <= 1'b0;
    rxw <= {1'b0, 8'($urandom)};
    wr(OFS_RX_STATUS_CONTROL, 8'ha0);
    wait_rx();
    rd(OFS_RX_DATA_BUFFER, rxw[7:0], 8'hff);
    repeat (4) @(posedge clock_i);
    end_of_test();
  end

endmodule : tb
